// file: src/ladder_bit_logic_unit.sv
// Bit-logic execution unit: contacts, block starts and block joins of a ladder program.
// Assumes one instruction per cycle from the sequencer and a 125 MHz clock.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module ladder_bit_logic_unit
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic instr_valid,
   input ladder_bit_pkg::op_e instr_op,
   input wire logic instr_closed,
   input wire logic instr_imm,
   input ladder_bit_pkg::edge_e instr_edge,
   input wire logic [ladder_bit_pkg::SLOT_W-1:0] instr_slot,
   input wire logic [ladder_bit_pkg::BIT_ADDR_W-1:0] instr_addr,
   input wire logic [ladder_bit_pkg::PIN_COUNT-1:0] input_pins,
   input wire logic [ladder_bit_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ladder_bit_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ladder_bit_pkg::DATA_W-1:0] reg_rdata,
   output logic exec_cond,
   output logic block_open,
   output logic [ladder_bit_pkg::DEPTH_W-1:0] pending_depth,
   output logic prog_error,
   output logic condition_flags_we
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic [ladder_bit_pkg::PIN_COUNT-1:0] pin_meta_ff, pin_sync_ff;
   logic [ladder_bit_pkg::IMAGE_BITS-1:0] image_ff, nxt_image;
   logic [ladder_bit_pkg::EDGE_SLOTS-1:0] prev_ff, nxt_prev;
   logic cond_ff, nxt_cond;
   ladder_bit_pkg::rung_e rung_ff, nxt_rung;
   logic [ladder_bit_pkg::ERR_W-1:0] err_ff, nxt_err, err_set;
   logic [ladder_bit_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
   logic is_contact, use_pin, opnd_val, prev_bit, raw_val, contrib;
   logic st_push, st_pop, st_flush, st_top, st_full, st_empty;
   logic [ladder_bit_pkg::DEPTH_W-1:0] st_depth;
   logic ctrl_wr, err_clear;

   ////////////////////////////////////////////////////////////////////////////////
   // Built-in terminals pass two flip-flops before any logic reads them.

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_meta_ff <= 16'h0;
         pin_sync_ff <= 16'h0;
      end
      else
      begin
         pin_meta_ff <= input_pins;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Operand selection and edge qualification.

   always_comb
   begin
      is_contact = instr_valid && (instr_op == ladder_bit_pkg::OP_BLK_START ||
                                   instr_op == ladder_bit_pkg::OP_SERIES ||
                                   instr_op == ladder_bit_pkg::OP_PARALLEL);
      use_pin = instr_imm && (instr_addr < ladder_bit_pkg::BUILTIN_LIMIT);
      // Immediate on a built-in address reads the terminal itself; otherwise the stored image is used.
      opnd_val = use_pin ? pin_sync_ff[instr_addr[3:0]] : image_ff[instr_addr];
      prev_bit = prev_ff[instr_slot];
      // Edge detection works on the refreshed value when immediate is also given.
      unique case (instr_edge)
         ladder_bit_pkg::EDGE_NONE: raw_val = opnd_val;
         ladder_bit_pkg::EDGE_RISE: raw_val = opnd_val && !prev_bit;
         ladder_bit_pkg::EDGE_FALL: raw_val = !opnd_val && prev_bit;
         default: raw_val = 1'b0;
      endcase
      contrib = raw_val ^ instr_closed;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Execution condition, rung state and pending-condition stack control.

   always_comb
   begin
      nxt_cond = cond_ff;
      nxt_rung = rung_ff;
      st_push = 1'b0;
      st_pop = 1'b0;
      st_flush = 1'b0;
      err_set = 4'h0;
      if (instr_valid)
      begin
         unique case (instr_op)
            ladder_bit_pkg::OP_BLK_START:
            begin
               // A new block opens; an open block's condition is kept pending unless the stack is full, which sets the overflow error.
               if (rung_ff == ladder_bit_pkg::RUNG_OPEN)
               begin
                  if (st_full)
                  begin
                     err_set[ladder_bit_pkg::ERR_OVERFLOW] = 1'b1;
                  end
                  else
                  begin
                     st_push = 1'b1;
                  end
               end
               nxt_cond = contrib;
               nxt_rung = ladder_bit_pkg::RUNG_OPEN;
            end
            ladder_bit_pkg::OP_SERIES:
            begin
               if (rung_ff == ladder_bit_pkg::RUNG_IDLE)
                  err_set[ladder_bit_pkg::ERR_RAIL] = 1'b1;
               nxt_cond = cond_ff & contrib;
            end
            ladder_bit_pkg::OP_PARALLEL:
            begin
               nxt_cond = cond_ff | contrib;
            end
            ladder_bit_pkg::OP_SERIES_JOIN:
            begin
               if (st_empty)
               begin
                  err_set[ladder_bit_pkg::ERR_UNDERFLOW] = 1'b1;
               end
               else
               begin
                  nxt_cond = cond_ff & st_top;
                  st_pop = 1'b1;
               end
            end
            ladder_bit_pkg::OP_PARALLEL_JOIN:
            begin
               if (st_empty)
               begin
                  err_set[ladder_bit_pkg::ERR_UNDERFLOW] = 1'b1;
               end
               else
               begin
                  nxt_cond = cond_ff | st_top;
                  st_pop = 1'b1;
               end
            end
            ladder_bit_pkg::OP_RUNG_END:
            begin
               // Leftover pending blocks mean too few joins for the block starts.
               if (!st_empty)
                  err_set[ladder_bit_pkg::ERR_MISMATCH] = 1'b1;
               st_flush = 1'b1;
               nxt_rung = ladder_bit_pkg::RUNG_IDLE;
            end
            default:
            begin
            end
         endcase
      end
      // A new error in the clearing cycle is kept.
      nxt_err = (err_clear ? 4'h0 : err_ff) | err_set;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cond_ff <= ladder_bit_pkg::RST_COND;
         rung_ff <= ladder_bit_pkg::RUNG_IDLE;
         err_ff <= ladder_bit_pkg::RST_ERR;
      end
      else
      begin
         cond_ff <= nxt_cond;
         rung_ff <= nxt_rung;
         err_ff <= nxt_err;
      end
   end

   block_stack u_stack
   (
      .clk(clk),
      .arst_n(arst_n),
      .push(st_push),
      .pop(st_pop),
      .flush(st_flush),
      .push_bit(cond_ff),
      .top_bit(st_top),
      .depth(st_depth),
      .full(st_full),
      .empty(st_empty)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Previous-scan copies for edge-qualified contacts.

   always_comb
   begin
      nxt_prev = prev_ff;
      if (is_contact && instr_edge != ladder_bit_pkg::EDGE_NONE)
      begin
         nxt_prev[instr_slot] = opnd_val;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prev_ff <= ladder_bit_pkg::RST_PREV;
      end
      else
      begin
         prev_ff <= nxt_prev;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Memory image and register port.

   assign ctrl_wr = reg_wr && (reg_addr == ladder_bit_pkg::REG_CTRL);
   assign err_clear = ctrl_wr && reg_wdata[ladder_bit_pkg::CTRL_CLEAR_BIT];

   always_comb
   begin
      nxt_image = image_ff;
      if (reg_wr && reg_addr <= ladder_bit_pkg::REG_IMAGE3)
      begin
         nxt_image[reg_addr[1:0]*ladder_bit_pkg::DATA_W +: ladder_bit_pkg::DATA_W] = reg_wdata;
      end
      // Cyclic refresh copies every built-in terminal into the image.
      if (ctrl_wr && reg_wdata[ladder_bit_pkg::CTRL_REFRESH_BIT])
      begin
         nxt_image[ladder_bit_pkg::PIN_COUNT-1:0] = pin_sync_ff;
      end
      if (is_contact && use_pin)
      begin
         nxt_image[instr_addr] = pin_sync_ff[instr_addr[3:0]];
      end
   end

   always_comb
   begin
      nxt_rdata = 16'h0;
      if (reg_rd)
      begin
         if (reg_addr <= ladder_bit_pkg::REG_IMAGE3)
         begin
            nxt_rdata = image_ff[reg_addr[1:0]*ladder_bit_pkg::DATA_W +: ladder_bit_pkg::DATA_W];
         end
         else if (reg_addr == ladder_bit_pkg::REG_STATUS)
         begin
            nxt_rdata[ladder_bit_pkg::ST_COND_BIT] = cond_ff;
            nxt_rdata[ladder_bit_pkg::ST_OPEN_BIT] = (rung_ff == ladder_bit_pkg::RUNG_OPEN);
            nxt_rdata[ladder_bit_pkg::ST_DEPTH_LSB +: ladder_bit_pkg::DEPTH_W] = st_depth;
            nxt_rdata[ladder_bit_pkg::ST_ERR_LSB +: ladder_bit_pkg::ERR_W] = err_ff;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         image_ff <= ladder_bit_pkg::RST_IMAGE;
         rdata_ff <= ladder_bit_pkg::RST_RDATA;
      end
      else
      begin
         image_ff <= nxt_image;
         rdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign reg_rdata = rdata_ff;
   assign exec_cond = cond_ff;
   assign block_open = (rung_ff == ladder_bit_pkg::RUNG_OPEN);
   assign pending_depth = st_depth;
   assign prog_error = |err_ff;
   // The unit never writes the controller's condition flags.
   assign condition_flags_we = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_series_contact;
      instr_valid && instr_op == ladder_bit_pkg::OP_SERIES;
   endsequence
   sequence s_parallel_contact;
      instr_valid && instr_op == ladder_bit_pkg::OP_PARALLEL;
   endsequence
   sequence s_join(ladder_bit_pkg::op_e op);
      instr_valid && instr_op == op && !st_empty;
   endsequence
   a_series_and: assert property (s_series_contact |=>
      cond_ff == ($past(cond_ff) && $past(contrib)))
      else $error("Series contact did not AND into the condition.");
   a_parallel_or: assert property (s_parallel_contact |=>
      cond_ff == ($past(cond_ff) || $past(contrib)))
      else $error("Parallel contact did not OR into the condition.");
   a_closed_invert: assert property (
      instr_valid && instr_closed && instr_edge == ladder_bit_pkg::EDGE_NONE
      |-> contrib == !opnd_val)
      else $error("Closed contact did not invert its operand.");
   a_cached_operand: assert property (instr_valid && !instr_imm |->
      opnd_val == image_ff[instr_addr])
      else $error("Ordinary contact did not read the memory image.");
   a_immediate_refresh: assert property (is_contact && use_pin |->
      opnd_val == pin_sync_ff[instr_addr[3:0]]
      ##1 image_ff[$past(instr_addr)] == $past(opnd_val))
      else $error("Immediate contact did not refresh the image bit.");
   a_rise_edge: assert property (instr_edge == ladder_bit_pkg::EDGE_RISE |->
      raw_val == (opnd_val && !prev_ff[instr_slot]))
      else $error("Rising edge contact gave the wrong value.");
   a_fall_edge: assert property (instr_edge == ladder_bit_pkg::EDGE_FALL |->
      raw_val == (!opnd_val && prev_ff[instr_slot]))
      else $error("Falling edge contact gave the wrong value.");
   a_series_join: assert property (s_join(ladder_bit_pkg::OP_SERIES_JOIN) |=>
      cond_ff == ($past(cond_ff) && $past(st_top)) && st_depth == $past(st_depth) - 4'h1)
      else $error("Series join did not AND with the pending block.");
   a_parallel_join: assert property (s_join(ladder_bit_pkg::OP_PARALLEL_JOIN) |=>
      cond_ff == ($past(cond_ff) || $past(st_top)) && st_depth == $past(st_depth) - 4'h1)
      else $error("Parallel join did not OR with the pending block.");
   a_block_push: assert property (
      instr_valid && instr_op == ladder_bit_pkg::OP_BLK_START && block_open && !st_full
      |=> st_depth == $past(st_depth) + 4'h1 && st_top == $past(cond_ff)
      && cond_ff == $past(contrib))
      else $error("Block start did not keep the old condition pending.");
   a_join_mismatch: assert property (
      instr_valid && instr_op == ladder_bit_pkg::OP_RUNG_END && !st_empty
      |=> err_ff[ladder_bit_pkg::ERR_MISMATCH] && prog_error && st_depth == 4'h0)
      else $error("Unbalanced rung did not raise the mismatch error.");
   a_edge_memory: assert property (is_contact && instr_edge != ladder_bit_pkg::EDGE_NONE
      |=> prev_ff[$past(instr_slot)] == $past(opnd_val))
      else $error("Edge contact did not keep its previous-scan copy.");

endmodule

// file: pkg/ladder_bit_pkg.sv
// Constants, opcodes and register map shared by the bit-logic unit and its stack.
// Assumes a single 125 MHz clock domain and a plain register port with 16-bit data.
package ladder_bit_pkg;

   // Register port geometry.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Image of the input/output memory: four 16-bit words, bit address 0..63.
   localparam int IMAGE_WORDS = 4;
   localparam int IMAGE_BITS = 64;
   localparam int BIT_ADDR_W = 6;

   // Built-in input terminals occupy bit addresses below this limit.
   localparam int PIN_COUNT = 16;
   localparam logic [5:0] BUILTIN_LIMIT = 6'h10;

   // Pending block conditions and per-instance edge memories.
   localparam int STACK_DEPTH = 8;
   localparam int DEPTH_W = 4;
   localparam int EDGE_SLOTS = 8;
   localparam int SLOT_W = 3;

   // Register offsets.
   localparam logic [3:0] REG_IMAGE0 = 4'h0;
   localparam logic [3:0] REG_IMAGE3 = 4'h3;
   localparam logic [3:0] REG_CTRL = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h5;

   // Control register bits, both write-one pulses.
   localparam int CTRL_REFRESH_BIT = 0;
   localparam int CTRL_CLEAR_BIT = 1;

   // Status register fields.
   localparam int ST_COND_BIT = 0;
   localparam int ST_OPEN_BIT = 1;
   localparam int ST_DEPTH_LSB = 2;
   localparam int ST_ERR_LSB = 8;

   // Sticky error bits, in the order held in the error vector.
   localparam int ERR_W = 4;
   localparam int ERR_MISMATCH = 0;
   localparam int ERR_OVERFLOW = 1;
   localparam int ERR_UNDERFLOW = 2;
   localparam int ERR_RAIL = 3;

   // Values after reset.
   localparam logic RST_COND = 1'b0;
   localparam logic [IMAGE_BITS-1:0] RST_IMAGE = 64'h0;
   localparam logic [EDGE_SLOTS-1:0] RST_PREV = 8'h0;
   localparam logic [ERR_W-1:0] RST_ERR = 4'h0;
   localparam logic [DATA_W-1:0] RST_RDATA = 16'h0;

   typedef enum logic [2:0] {
      OP_NOP = 3'h0,
      OP_BLK_START = 3'h1,
      OP_SERIES = 3'h2,
      OP_PARALLEL = 3'h3,
      OP_SERIES_JOIN = 3'h4,
      OP_PARALLEL_JOIN = 3'h5,
      OP_RUNG_END = 3'h6
   } op_e;

   typedef enum logic [1:0] {
      EDGE_NONE = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2
   } edge_e;

   typedef enum logic [1:0] {
      RUNG_IDLE = 2'b01,
      RUNG_OPEN = 2'b10
   } rung_e;

endpackage

// file: src/block_stack.sv
// Last-in-first-out store of pending one-bit block conditions.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/1ns
module block_stack
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic push,
   input wire logic pop,
   input wire logic flush,
   input wire logic push_bit,
   output logic top_bit,
   output logic [ladder_bit_pkg::DEPTH_W-1:0] depth,
   output logic full,
   output logic empty
);

   logic [ladder_bit_pkg::STACK_DEPTH-1:0] mem_ff;
   logic [ladder_bit_pkg::STACK_DEPTH-1:0] nxt_mem;
   logic [ladder_bit_pkg::DEPTH_W-1:0] depth_ff;
   logic [ladder_bit_pkg::DEPTH_W-1:0] nxt_depth;

   assign depth = depth_ff;
   assign empty = (depth_ff == 4'h0);
   assign full = (depth_ff == 4'(ladder_bit_pkg::STACK_DEPTH));
   assign top_bit = empty ? 1'b0 : mem_ff[3'(depth_ff - 4'h1)];

   always_comb
   begin
      nxt_mem = mem_ff;
      nxt_depth = depth_ff;
      if (flush)
      begin
         nxt_depth = 4'h0;
      end
      else if (push && !full)
      begin
         nxt_mem[3'(depth_ff)] = push_bit;
         nxt_depth = depth_ff + 4'h1;
      end
      else if (pop && !empty)
      begin
         nxt_depth = depth_ff - 4'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mem_ff <= 8'h0;
         depth_ff <= 4'h0;
      end
      else
      begin
         mem_ff <= nxt_mem;
         depth_ff <= nxt_depth;
      end
   end

endmodule

// file: verification/instr_sequencer_model.sv
// Model of the controller's instruction sequencer that feeds the bit-logic unit.
// Assumes issue and idle are called by the bench, each taking one clock cycle.
`timescale 1ns/1ns
module instr_sequencer_model
(
   input wire logic clk,
   output logic instr_valid,
   output ladder_bit_pkg::op_e instr_op,
   output logic instr_closed,
   output logic instr_imm,
   output ladder_bit_pkg::edge_e instr_edge,
   output logic [2:0] instr_slot,
   output logic [5:0] instr_addr
);
   initial
   begin
      instr_valid = 1'b0;
      instr_op = ladder_bit_pkg::OP_NOP;
      instr_closed = 1'b0;
      instr_imm = 1'b0;
      instr_edge = ladder_bit_pkg::EDGE_NONE;
      instr_slot = 3'h0;
      instr_addr = 6'h0;
   end

   // Programs open a block before any series contact and keep at most eight block starts
   // pending; only the refusal tests send anything else.
   task automatic issue(input ladder_bit_pkg::op_e op, input logic [5:0] a, input logic cl,
                        input logic im, input ladder_bit_pkg::edge_e ed, input logic [2:0] sl);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_op <= op;
      instr_addr <= a;
      instr_closed <= cl;
      instr_imm <= im;
      instr_edge <= ed;
      instr_slot <= sl;
   endtask

   task automatic idle();
      @(posedge clk);
      instr_valid <= 1'b0;
      instr_op <= ladder_bit_pkg::OP_NOP;
   endtask
endmodule

// file: verification/ladder_bit_logic_unit_tb.sv
// Self-checking bench for the bit-logic unit: register tasks, instruction sequences.
// Assumes the sequencer model drives the instruction port and the bench drives the rest.
`timescale 1ns/1ns
module ladder_bit_logic_unit_tb;
   localparam ladder_bit_pkg::op_e blk = ladder_bit_pkg::OP_BLK_START;
   localparam ladder_bit_pkg::op_e ser = ladder_bit_pkg::OP_SERIES;
   localparam ladder_bit_pkg::op_e par = ladder_bit_pkg::OP_PARALLEL;
   localparam ladder_bit_pkg::op_e sj = ladder_bit_pkg::OP_SERIES_JOIN;
   localparam ladder_bit_pkg::op_e pj = ladder_bit_pkg::OP_PARALLEL_JOIN;
   localparam ladder_bit_pkg::op_e rend = ladder_bit_pkg::OP_RUNG_END;
   localparam ladder_bit_pkg::edge_e none = ladder_bit_pkg::EDGE_NONE;
   localparam ladder_bit_pkg::edge_e rise = ladder_bit_pkg::EDGE_RISE;
   localparam ladder_bit_pkg::edge_e fall = ladder_bit_pkg::EDGE_FALL;

   logic clk, arst_n, instr_valid, instr_closed, instr_imm, reg_wr, reg_rd;
   ladder_bit_pkg::op_e instr_op;
   ladder_bit_pkg::edge_e instr_edge;
   logic [2:0] instr_slot;
   logic [5:0] instr_addr;
   logic [15:0] input_pins, reg_wdata, reg_rdata;
   logic [3:0] reg_addr, pending_depth;
   logic exec_cond, block_open, prog_error, condition_flags_we;
   int mismatches = 0;
   int total_checks = 0;

   ladder_bit_logic_unit DUT (.clk, .arst_n, .instr_valid, .instr_op, .instr_closed,
      .instr_imm, .instr_edge, .instr_slot, .instr_addr, .input_pins, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .exec_cond, .block_open, .pending_depth, .prog_error,
      .condition_flags_we);
   instr_sequencer_model seq (.clk, .instr_valid, .instr_op, .instr_closed, .instr_imm,
      .instr_edge, .instr_slot, .instr_addr);

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
      end
   endtask

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic op(input ladder_bit_pkg::op_e o, input logic [5:0] a, input logic cl = 1'b0,
                     input logic im = 1'b0, input ladder_bit_pkg::edge_e ed = none,
                     input logic [2:0] sl = 3'h0);
      seq.issue(o, a, cl, im, ed, sl);
   endtask

   task automatic step();
      seq.idle();
      #1;
   endtask

   function automatic logic [15:0] st(input logic [3:0] e, input logic [3:0] dp,
                                      input logic o, input logic c);
      st = {4'h0, e, 2'h0, dp, o, c};
   endfunction

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      #100000;
      mismatches++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [15:0] d;
      logic e, pv, v;
      arst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0;
      input_pins = 16'h0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      rd(4'h5, d);
      chk_word(d, 16'h0000);
      wr(4'h9, 16'hffff);
      rd(4'h9, d);
      chk_word(d, 16'h0000);
      wr(4'h1, 16'h0002);
      rd(4'h1, d);
      chk_word(d, 16'h0002);
      $display("test registers done");

      // Bit 16 is OFF and bit 17 is ON in the image.
      for (int k = 0; k < 16; k++)
      begin
         op(blk, k[0] ? 6'h11 : 6'h10);
         op(k[3] ? par : ser, k[1] ? 6'h11 : 6'h10, k[2]);
         op(rend, 6'h0);
         step();
         e = k[3] ? (k[0] | (k[1] ^ k[2])) : (k[0] & (k[1] ^ k[2]));
         chk_bit(exec_cond, e);
      end
      $display("test contacts done");

      op(blk, 6'h11);
      op(blk, 6'h10);
      op(blk, 6'h11);
      step();
      chk_word({12'h0, pending_depth}, 16'h0002);
      chk_bit(block_open, 1'b1);
      op(pj, 6'h0);
      op(sj, 6'h0);
      step();
      chk_bit(exec_cond, 1'b1);
      op(rend, 6'h0);
      op(blk, 6'h11);
      op(blk, 6'h10);
      op(sj, 6'h0);
      op(rend, 6'h0);
      step();
      chk_bit(exec_cond, 1'b0);
      chk_bit(prog_error, 1'b0);
      chk_bit(block_open, 1'b0);
      $display("test joins done");

      op(blk, 6'h10);
      op(blk, 6'h10);
      op(rend, 6'h0);
      step();
      rd(4'h5, d);
      chk_word(d, st(4'h1, 4'h0, 1'b0, 1'b0));
      wr(4'h4, 16'h0002);
      op(ser, 6'h11);
      step();
      rd(4'h5, d);
      chk_word({12'h0, d[11:8]}, 16'h0008);
      wr(4'h4, 16'h0002);
      op(rend, 6'h0);
      op(pj, 6'h0);
      step();
      rd(4'h5, d);
      chk_word({12'h0, d[11:8]}, 16'h0004);
      wr(4'h4, 16'h0002);
      for (int k = 0; k < 9; k++)
         op(blk, 6'h11);
      step();
      chk_word({12'h0, pending_depth}, 16'h0008);
      chk_bit(prog_error, 1'b0);
      op(blk, 6'h11);
      step();
      rd(4'h5, d);
      chk_word(d, st(4'h2, 4'h8, 1'b1, 1'b1));
      op(rend, 6'h0);
      wr(4'h4, 16'h0002);
      $display("test errors done");

      @(posedge clk);
      input_pins <= 16'h0008;
      repeat (3) @(posedge clk);
      op(blk, 6'h03, 1'b0, 1'b1);
      op(rend, 6'h0);
      step();
      chk_bit(exec_cond, 1'b1);
      rd(4'h0, d);
      chk_word(d, 16'h0008);
      @(posedge clk);
      input_pins <= 16'h0000;
      repeat (3) @(posedge clk);
      op(blk, 6'h03);
      op(rend, 6'h0);
      step();
      chk_bit(exec_cond, 1'b1);
      // A cyclic refresh copies the now low terminals into image word 0.
      wr(4'h4, 16'h0001);
      rd(4'h0, d);
      chk_word(d, 16'h0000);
      $display("test immediate done");

      pv = 1'b0;
      for (int k = 0; k < 5; k++)
      begin
         v = (k == 1 || k == 2);
         wr(4'h1, {14'h0, v, 1'b0});
         op(blk, 6'h10);
         op(par, 6'h11, 1'b0, 1'b0, rise, 3'h2);
         op(rend, 6'h0);
         step();
         chk_bit(exec_cond, v & ~pv);
         op(blk, 6'h10);
         op(par, 6'h11, 1'b0, 1'b0, fall, 3'h3);
         op(rend, 6'h0);
         step();
         chk_bit(exec_cond, ~v & pv);
         pv = v;
      end
      @(posedge clk);
      input_pins <= 16'h0020;
      repeat (3) @(posedge clk);
      for (int k = 0; k < 2; k++)
      begin
         op(blk, 6'h10);
         op(par, 6'h05, 1'b0, 1'b1, rise, 3'h4);
         op(rend, 6'h0);
         step();
         chk_bit(exec_cond, k == 0);
      end
      chk_bit(condition_flags_we, 1'b0);
      $display("test edges done");
      report_and_stop();
   end
endmodule
